// ### rx_ctrl_regs.vh
// Bit positions, widths and reset values for the receive control block.
`ifndef RX_CTRL_REGS_VH
`define RX_CTRL_REGS_VH
`define WORD_LEN          36
`define WORD_RESET        36'h000000000
`define CNT_W             6
`define CNT_LAST          6'h23
`define POS_REF_VCO_SEL   0
`define POS_MAIN_LO       1
`define POS_MAIN_HI       8
`define POS_SWAL_LO       9
`define POS_SWAL_HI       12
`define POS_REFDIV_LO     13
`define POS_REFDIV_HI     23
`define POS_CP_POL        24
`define POS_DMAIN_LO      25
`define POS_DMAIN_HI      32
`define POS_DSWAL_LO      33
`define POS_DSWAL_HI      34
`define POS_SYN_PD        35
`define MODE_SLEEP        3'h0
`define MODE_STANDBY      3'h1
`define MODE_ACTIVE       3'h2
`define MODE_EXT_OSC      3'h3
`define MODE_UNDEF        3'h4
`endif

// ### pin_sync.v
// Two-flip-flop synchroniser for a group of pin inputs.
module pin_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         sys_rst,
    input  wire [W-1:0] pin_in,
    output reg  [W-1:0] pin_out
);
    reg [W-1:0] meta_r;

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_r  <= {W{1'b0}};
            pin_out <= {W{1'b0}};
        end
        else
        begin
            meta_r  <= pin_in;
            pin_out <= meta_r;
        end
    end
endmodule // pin_sync

// ### rx_mode_ctrl.v
// Mode decode of control pins and three-wire synthesizer programming port.
`include "rx_ctrl_regs.vh"
module rx_mode_ctrl (
    // Clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // Static control pins
    input  wire        power_enable,
    input  wire        standby_pin,
    input  wire        demod_osc_source_pin,
    input  wire        band_select,
    input  wire        front_amp_gain_select,
    input  wire        output_path_select,
    // Three-wire programming port
    input  wire        serial_clk,
    input  wire        serial_data,
    input  wire        load_strobe,
    // Mode and analog enables
    output reg  [2:0]  op_mode,
    output reg         low_amp_enable,
    output reg         high_amp_enable,
    output reg         amp_high_gain,
    output reg         iq_out_enable,
    output reg         if_out_enable,
    output reg         lo_buffer_enable,
    output reg         synth_enable,
    output reg         demod_div_enable,
    output reg         ext_demod_osc_enable,
    // Active synthesizer configuration
    output reg         ref_vco_select,
    output reg  [7:0]  synth_main_divider_bits,
    output reg  [3:0]  synth_swallow_bits,
    output reg  [10:0] synth_reference_divider_bits,
    output reg         charge_pump_polarity,
    output reg  [7:0]  demod_main_divider_bits,
    output reg  [1:0]  demod_swallow_bits,
    output reg         synth_power_down,
    output reg         config_loaded
);
    wire [8:0] pins_s;
    reg        sclk_d_r;
    reg        strobe_d_r;
    reg [`WORD_LEN-1:0] shift_r;
    reg [`WORD_LEN-1:0] word_r;
    reg [`CNT_W-1:0]    count_r;
    reg        full_r;
    reg [2:0]  mode_nxt;
    wire       pwr;
    wire       stby;
    wire       src;
    wire       band;
    wire       gain;
    wire       path;
    wire       sclk;
    wire       sdat;
    wire       strb;

    pin_sync #(.W(9)) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin_in  ({power_enable, standby_pin, demod_osc_source_pin, band_select,
                   front_amp_gain_select, output_path_select, serial_clk,
                   serial_data, load_strobe}),
        .pin_out (pins_s)
    );

    assign pwr  = pins_s[8];
    assign stby = pins_s[7];
    assign src  = pins_s[6];
    assign band = pins_s[5];
    assign gain = pins_s[4];
    assign path = pins_s[3];
    assign sclk = pins_s[2];
    assign sdat = pins_s[1];
    assign strb = pins_s[0];

    // Mode decode; combinations absent from the truth table fall to undefined, which turns off the amplifiers and outputs.
    always @*
    begin
        if (pwr && !src)
            mode_nxt = `MODE_EXT_OSC;
        else if (pwr && stby && src)
            mode_nxt = `MODE_ACTIVE;
        else if (!pwr && stby && src)
            mode_nxt = `MODE_STANDBY;
        else if (!pwr && !stby && !src)
            mode_nxt = `MODE_SLEEP;
        else
            mode_nxt = `MODE_UNDEF;
    end

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            op_mode              <= `MODE_SLEEP;
            low_amp_enable       <= 1'b0;
            high_amp_enable      <= 1'b0;
            amp_high_gain        <= 1'b0;
            iq_out_enable        <= 1'b0;
            if_out_enable        <= 1'b0;
            lo_buffer_enable     <= 1'b0;
            synth_enable         <= 1'b0;
            demod_div_enable     <= 1'b0;
            ext_demod_osc_enable <= 1'b0;
        end
        else
        begin
            op_mode <= mode_nxt;
            case (mode_nxt)
                `MODE_ACTIVE:
                begin
                    low_amp_enable   <= !band;
                    high_amp_enable  <= band;
                    amp_high_gain    <= gain;
                    iq_out_enable    <= !path;
                    if_out_enable    <= path;
                end
                `MODE_EXT_OSC:
                begin
                    low_amp_enable   <= !band;
                    high_amp_enable  <= band;
                    amp_high_gain    <= gain;
                    iq_out_enable    <= !path;
                    if_out_enable    <= path;
                end
                default:
                begin
                    low_amp_enable   <= 1'b0;
                    high_amp_enable  <= 1'b0;
                    amp_high_gain    <= 1'b0;
                    iq_out_enable    <= 1'b0;
                    if_out_enable    <= 1'b0;
                end
            endcase
            // Standby pin gates the LO buffer and synthesizer, the source pin the demod divider, unless asleep.
            lo_buffer_enable     <= stby && (mode_nxt != `MODE_SLEEP);
            synth_enable         <= stby && (mode_nxt != `MODE_SLEEP)
                                    && !word_r[`POS_SYN_PD];
            demod_div_enable     <= src && (mode_nxt != `MODE_SLEEP);
            ext_demod_osc_enable <= !src && (mode_nxt == `MODE_EXT_OSC);
        end
    end

    // Serial shift register; the strobe edge commits only a complete word.
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            sclk_d_r      <= 1'b0;
            strobe_d_r    <= 1'b0;
            shift_r       <= `WORD_RESET;
            word_r        <= `WORD_RESET;
            count_r       <= {`CNT_W{1'b0}};
            full_r        <= 1'b0;
            config_loaded <= 1'b0;
        end
        else
        begin
            sclk_d_r   <= sclk;
            strobe_d_r <= strb;
            if (strb && !strobe_d_r)
            begin
                if (full_r)
                begin
                    word_r        <= shift_r;
                    config_loaded <= 1'b1;
                end
                count_r <= {`CNT_W{1'b0}};
                full_r  <= 1'b0;
            end
            else if (sclk && !sclk_d_r)
            begin
                // Last bit shifted becomes bit 35; bit 00 goes first.
                shift_r <= {sdat, shift_r[`WORD_LEN-1:1]};
                if (count_r == `CNT_LAST)
                    full_r <= 1'b1;
                else
                    count_r <= count_r + 6'h01;
            end
        end
    end

    always @*
    begin
        ref_vco_select               = word_r[`POS_REF_VCO_SEL];
        synth_main_divider_bits      = word_r[`POS_MAIN_HI:`POS_MAIN_LO];
        synth_swallow_bits           = word_r[`POS_SWAL_HI:`POS_SWAL_LO];
        synth_reference_divider_bits = word_r[`POS_REFDIV_HI:`POS_REFDIV_LO];
        charge_pump_polarity         = word_r[`POS_CP_POL];
        demod_main_divider_bits      = word_r[`POS_DMAIN_HI:`POS_DMAIN_LO];
        demod_swallow_bits           = word_r[`POS_DSWAL_HI:`POS_DSWAL_LO];
        synth_power_down             = word_r[`POS_SYN_PD];
    end
endmodule // rx_mode_ctrl

// ### rx_mode_ctrl_props.sv
// Concurrent checks on mode decode and programming outputs.
`include "rx_ctrl_regs.vh"
module rx_mode_ctrl_props (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       power_enable,
    input wire logic       standby_pin,
    input wire logic       demod_osc_source_pin,
    input wire logic       band_select,
    input wire logic       load_strobe,
    input wire logic [2:0] op_mode,
    input wire logic       high_amp_enable,
    input wire logic       synth_enable,
    input wire logic [7:0] synth_main_divider_bits,
    input wire logic       config_loaded
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [2:0] age_r;
    wire        ok = age_r == 3'h7;
    wire  [2:0] p = {power_enable, standby_pin, demod_osc_source_pin};
    always_ff @(posedge clk)
        age_r <= sys_rst ? 3'h0 : age_r + {2'h0, !ok};
    property p_act; ok && $past(p, 3) == 3'h7 |-> op_mode == `MODE_ACTIVE; endproperty
    a_act: assert property (p_act) else $error("active");
    property p_stb; ok && $past(p, 3) == 3'h3 |-> op_mode == `MODE_STANDBY; endproperty
    a_stb: assert property (p_stb) else $error("standby");
    property p_slp; ok && $past(p, 3) == 3'h0 |-> op_mode == `MODE_SLEEP; endproperty
    a_slp: assert property (p_slp) else $error("sleep");
    property p_ext; ok && $past(p, 3) ==? 3'b1?0 |-> op_mode == `MODE_EXT_OSC; endproperty
    a_ext: assert property (p_ext) else $error("ext osc");
    property p_band;
        ok && op_mode == `MODE_ACTIVE |-> high_amp_enable == $past(band_select, 3);
    endproperty
    a_band: assert property (p_band) else $error("band");
    property p_syn; ok && synth_enable |-> $past(standby_pin, 3); endproperty
    a_syn: assert property (p_syn) else $error("synth");
    property p_load;
        ok && $changed(synth_main_divider_bits) |-> $past(load_strobe, 3) && !$past(load_strobe, 4);
    endproperty
    a_load: assert property (p_load) else $error("load");
    property p_rst; $fell(sys_rst) |-> !config_loaded && synth_main_divider_bits == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("reset");
endmodule // rx_mode_ctrl_props
bind rx_mode_ctrl rx_mode_ctrl_props chk (.clk, .sys_rst, .power_enable, .standby_pin,
    .demod_osc_source_pin, .band_select, .load_strobe, .op_mode, .high_amp_enable,
    .synth_enable, .synth_main_divider_bits, .config_loaded);

// ### ctrl_host_model.sv
// Controller model driving the three-wire programming port.
module ctrl_host_model (
    output logic serial_clk,
    output logic serial_data,
    output logic load_strobe
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b0;
    end
    // Sends n bits from bit 00 up; the clock rests low outside frames.
    task automatic shift(input logic [35:0] w, input int n);
        #1;
        for (int i = 0; i < n; i++)
        begin
            serial_data = w[i];
            #40 serial_clk = 1'b1;
            #40 serial_clk = 1'b0;
        end
        serial_data = !serial_data;
    endtask
    task automatic strobe();
        #40 load_strobe = 1'b1;
        #40 load_strobe = 1'b0;
    endtask
endmodule // ctrl_host_model

// ### rx_mode_ctrl_synth_serial_prog_bench.sv
// Self-checking bench for mode decode and synthesizer programming.
`include "rx_ctrl_regs.vh"
module rx_mode_ctrl_synth_serial_prog_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [5:0]  pins = 6'h00;
    logic [36:0] cur = 37'h0;
    logic [48:0] q[$];
    logic [48:0] last_e = 49'h0;
    logic [48:0] seen = 49'h0;
    wire         serial_clk, serial_data, load_strobe;
    wire  [48:0] obs;
    int          fail_count = 0;
    int          n_checks = 0;
    always #2.5 clk = ~clk;
    ctrl_host_model host (.serial_clk, .serial_data, .load_strobe);
    rx_mode_ctrl uut (.clk, .sys_rst, .power_enable(pins[5]), .standby_pin(pins[4]),
        .demod_osc_source_pin(pins[3]), .band_select(pins[2]),
        .front_amp_gain_select(pins[1]), .output_path_select(pins[0]), .serial_clk,
        .serial_data, .load_strobe, .op_mode(obs[48:46]), .low_amp_enable(obs[45]),
        .high_amp_enable(obs[44]), .amp_high_gain(obs[43]), .iq_out_enable(obs[42]),
        .if_out_enable(obs[41]), .lo_buffer_enable(obs[40]), .synth_enable(obs[39]),
        .demod_div_enable(obs[38]), .ext_demod_osc_enable(obs[37]), .config_loaded(obs[36]),
        .ref_vco_select(obs[0]), .synth_main_divider_bits(obs[8:1]),
        .synth_swallow_bits(obs[12:9]), .synth_reference_divider_bits(obs[23:13]),
        .charge_pump_polarity(obs[24]), .demod_main_divider_bits(obs[32:25]),
        .demod_swallow_bits(obs[34:33]), .synth_power_down(obs[35]));
    function automatic logic [48:0] model_out(input logic [5:0] p, input logic [36:0] c);
        logic [2:0] m;
        logic       a;
        logic       on;
        m = (p[5] && !p[3]) ? `MODE_EXT_OSC : p[5:3] == 3'h7 ? `MODE_ACTIVE :
            p[5:3] == 3'h3 ? `MODE_STANDBY : p[5:3] == 3'h0 ? `MODE_SLEEP : `MODE_UNDEF;
        a = m == `MODE_ACTIVE || m == `MODE_EXT_OSC;
        on = m != `MODE_SLEEP;
        return {m, a && !p[2], a && p[2], a && p[1], a && !p[0], a && p[0], p[4] && on,
                p[4] && on && !c[35], p[3] && on, m == `MODE_EXT_OSC, c};
    endfunction
    task automatic check(input logic [48:0] got, input logic [48:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD outputs expected %h seen %h", exp, got);
        end
    endtask
    // Queues the expected outputs only when they differ from the last ones.
    task automatic note();
        logic [48:0] e;
        e = sys_rst ? 49'h0 : model_out(pins, cur);
        if (e !== last_e)
            q.push_back(e);
        last_e = e;
    endtask
    task automatic set_pins(input logic [5:0] p);
        @(posedge clk);
        #1 pins = p;
        note();
        repeat (6) @(posedge clk);
    endtask
    task automatic commit(input logic [35:0] w);
        host.shift(w, 36);
        cur = {1'b1, w};
        note();
        host.strobe();
        repeat (6) @(posedge clk);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(negedge clk)
    begin
        if (obs !== seen)
            check(obs, q.size() != 0 ? q.pop_front() : seen);
        seen = obs;
    end
    initial
    begin
        void'($urandom(32'h8143));
        repeat (2) @(posedge clk);
        #1 sys_rst = 1'b0;
        for (int i = 0; i < 64; i++)
            set_pins(6'(i));
        set_pins(6'h25);
        commit(36'hFFFFFFFFF);
        for (int i = 0; i < 4; i++)
            commit(36'({$urandom, $urandom}));
        host.shift(36'h0, 20);
        host.strobe();
        host.shift(36'h5, 4);
        commit(36'h000000001);
        @(posedge clk);
        #1 sys_rst = 1'b1;
        note();
        repeat (2) @(posedge clk);
        #1 sys_rst = 1'b0;
        cur = 37'h0;
        note();
        repeat (6) @(posedge clk);
        commit(36'({$urandom, $urandom}));
        for (int i = 0; i < 50 && q.size() != 0; i++)
            @(posedge clk);
        check(49'(q.size()), 49'h0);
        results();
    end
endmodule // rx_mode_ctrl_synth_serial_prog_bench
